//--- hw/dvm_top.v
// dac digital volume, mute, auto mute and channel linking stage
// assumes samples arrive on pclk with a one-cycle strobe per word clock
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "dvm_defs.vh"
module dvm_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        in_valid,
   input  wire [15:0] in_left,
   input  wire [15:0] in_right,
   output reg         out_valid,
   output reg  [15:0] out_left,
   output reg  [15:0] out_right
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function [7:0] step_to;
      input [7:0] cur;
      input [7:0] tgt;
      begin
         if ($signed(cur) < $signed(tgt))
            step_to = cur + 8'h01;
         else if ($signed(cur) > $signed(tgt))
            step_to = cur - 8'h01;
         else
            step_to = cur;
      end
   endfunction

   function [13:0] amute_limit;
      input [2:0] c;
      begin
         amute_limit = `DVM_AMUTE_BASE << (c - 3'h1);
      end
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg  [7:0]  setup_one_reg;
   reg  [7:0]  setup_two_reg;
   reg  [7:0]  left_gain_reg;
   reg  [7:0]  right_gain_reg;
   reg  [7:0]  left_applied_reg;
   reg  [7:0]  right_applied_reg;
   reg  [13:0] same_cnt_reg;
   reg         auto_mute_reg;
   reg         phase_reg;
   reg  [15:0] prev_left_reg;
   reg  [15:0] prev_right_reg;

   wire [7:0]  idx = paddr[9:2];
   wire        addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
   wire        bus_done = psel && penable && pready;
   wire        wr_en = bus_done && pwrite && !pslverr;

   // ----------------------------------------
   // apb slave, one wait state per access
   // ----------------------------------------
   reg  [31:0] rd_mux;
   reg         rd_hit;
   always @* begin
      rd_mux = 32'h00000000;
      rd_hit = addr_ok;
      case (idx)
         `DVM_IDX_SETUP_ONE:  rd_mux = {24'h000000, setup_one_reg};
         `DVM_IDX_SETUP_TWO:  rd_mux = {24'h000000, setup_two_reg};
         `DVM_IDX_LEFT_GAIN:  rd_mux = {24'h000000, left_gain_reg};
         `DVM_IDX_RIGHT_GAIN: rd_mux = {24'h000000, right_gain_reg};
         `DVM_IDX_STATUS:     rd_mux = {15'h0000, auto_mute_reg,
                                        right_applied_reg,
                                        left_applied_reg};
         default:             rd_hit = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            pslverr <= !rd_hit || (pwrite && idx == `DVM_IDX_STATUS);
            // refused reads return zero, not the decoded register
            prdata  <= (pwrite || !rd_hit) ? 32'h00000000 : rd_mux;
         end else begin
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setup_one_reg  <= `DVM_RST_SETUP_ONE;
         setup_two_reg  <= `DVM_RST_SETUP_TWO;
         left_gain_reg  <= `DVM_RST_GAIN;
         right_gain_reg <= `DVM_RST_GAIN;
      end else if (wr_en) begin
         case (idx)
            `DVM_IDX_SETUP_ONE:  setup_one_reg  <= pwdata[7:0];
            `DVM_IDX_SETUP_TWO:  setup_two_reg  <= pwdata[7:0];
            `DVM_IDX_LEFT_GAIN:  left_gain_reg  <= pwdata[7:0];
            `DVM_IDX_RIGHT_GAIN: right_gain_reg <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // auto mute detector
   // ----------------------------------------
   wire [2:0] amute_code = setup_two_reg[`DVM_F_AMUTE];
   wire       same_in = (in_left == prev_left_reg) &&
                        (in_right == prev_right_reg);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_left_reg  <= 16'h0000;
         prev_right_reg <= 16'h0000;
         same_cnt_reg   <= 14'h0000;
         auto_mute_reg  <= 1'b0;
      end else begin
         if (in_valid) begin
            prev_left_reg  <= in_left;
            prev_right_reg <= in_right;
            if (!same_in)
               same_cnt_reg <= 14'h0000;
            else if (same_cnt_reg != `DVM_CNT_MAX)
               same_cnt_reg <= same_cnt_reg + 14'h0001;
         end
         auto_mute_reg <= (amute_code != `DVM_AMUTE_OFF) &&
                          (same_cnt_reg >= amute_limit(amute_code));
      end
   end

   // ----------------------------------------
   // gain targets and ramp
   // ----------------------------------------
   wire [1:0] link = setup_two_reg[`DVM_F_LINK];
   wire [1:0] ramp = setup_one_reg[`DVM_F_RAMP];
   wire       left_mute = setup_two_reg[`DVM_F_LMUTE] || auto_mute_reg;
   wire       right_mute = setup_two_reg[`DVM_F_RMUTE] || auto_mute_reg;
   wire [7:0] left_set = (link == `DVM_LINK_L_FROM_R) ?
                         right_gain_reg : left_gain_reg;
   wire [7:0] right_set = (link == `DVM_LINK_R_FROM_L) ?
                          left_gain_reg : right_gain_reg;
   // mute ramps down to the lowest gain, then data is forced to zero
   wire [7:0] left_tgt = left_mute ? `DVM_GAIN_MIN : left_set;
   wire [7:0] right_tgt = right_mute ? `DVM_GAIN_MIN : right_set;

   wire       ramp_on = (ramp == `DVM_RAMP_EVERY) ||
                        (ramp == `DVM_RAMP_SECOND);
   wire       step_ok = (ramp == `DVM_RAMP_EVERY) || phase_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_applied_reg  <= `DVM_GAIN_MIN;
         right_applied_reg <= `DVM_GAIN_MIN;
         phase_reg         <= 1'b0;
      end else if (in_valid) begin
         phase_reg <= !phase_reg;
         // reserved rate code treated as no ramping
         if (!ramp_on) begin
            left_applied_reg  <= left_tgt;
            right_applied_reg <= right_tgt;
         end else if (step_ok) begin
            left_applied_reg  <= step_to(left_applied_reg, left_tgt);
            right_applied_reg <= step_to(right_applied_reg, right_tgt);
         end
      end
   end

   // ----------------------------------------
   // gain multipliers and output stage
   // ----------------------------------------
   wire [15:0] left_scaled;
   wire [15:0] right_scaled;
   dvm_gain_mult u_left_mult (
      .sample (in_left),
      .code   (left_applied_reg),
      .result (left_scaled)
   );
   dvm_gain_mult u_right_mult (
      .sample (in_right),
      .code   (right_applied_reg),
      .result (right_scaled)
   );

   wire        left_silent = left_mute &&
                             (left_applied_reg == `DVM_GAIN_MIN);
   wire        right_silent = right_mute &&
                              (right_applied_reg == `DVM_GAIN_MIN);
   wire        left_up = setup_one_reg[`DVM_F_LPWR];
   wire        right_up = setup_one_reg[`DVM_F_RPWR];
   wire [15:0] left_data = (left_up && !left_silent) ?
                           left_scaled : 16'h0000;
   reg  [15:0] right_data;
   always @* begin
      if (!right_up)
         right_data = setup_two_reg[`DVM_F_RMOD] ? ~left_data : 16'h0000;
      else if (right_silent)
         right_data = 16'h0000;
      else
         right_data = right_scaled;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_left  <= 16'h0000;
         out_right <= 16'h0000;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_left  <= left_data;
            out_right <= right_data;
         end
      end
   end
endmodule

//--- hw/dvm_defs.vh
// constants for the dac volume and mute stage
// assumes an apb3 master and an upstream sample strobe on pclk
`ifndef DVM_DEFS_VH
`define DVM_DEFS_VH
// ----------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------
`define DVM_IDX_SETUP_ONE  8'h3f
`define DVM_IDX_SETUP_TWO  8'h40
`define DVM_IDX_LEFT_GAIN  8'h41
`define DVM_IDX_RIGHT_GAIN 8'h42
`define DVM_IDX_STATUS     8'h50
// ----------------------------------------
// reset values
// ----------------------------------------
`define DVM_RST_SETUP_ONE  8'h14
`define DVM_RST_SETUP_TWO  8'h0c
`define DVM_RST_GAIN       8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define DVM_F_LPWR         7
`define DVM_F_RPWR         6
`define DVM_F_RAMP         1:0
`define DVM_F_RMOD         7
`define DVM_F_AMUTE        6:4
`define DVM_F_LMUTE        3
`define DVM_F_RMUTE        2
`define DVM_F_LINK         1:0
// ----------------------------------------
// encodings
// ----------------------------------------
`define DVM_RAMP_EVERY     2'b00
`define DVM_RAMP_SECOND    2'b01
`define DVM_LINK_L_FROM_R  2'b01
`define DVM_LINK_R_FROM_L  2'b10
`define DVM_AMUTE_OFF      3'h0
`define DVM_AMUTE_BASE     14'h0064
`define DVM_GAIN_MIN       8'h81
`define DVM_GAIN_OFFSET    9'h084
`define DVM_EXP_STEPS      9'h00c
`define DVM_SHIFT_BASE     6'h19
`define DVM_SAMPLE_MAX     16'h7fff
`define DVM_SAMPLE_MIN     16'h8000
`define DVM_CNT_MAX        14'h3fff
`endif

//--- hw/dvm_gain_mult.v
// half-decibel gain multiplier with saturation, purely combinational
// assumes the gain code is never a reserved value
`timescale 1ns/1ps
`include "dvm_defs.vh"
module dvm_gain_mult (
   input  wire [15:0] sample,
   input  wire [7:0]  code,
   output reg  [15:0] result
);
   // ----------------------------------------
   // mantissa table, 2^(r/12) in q14
   // ----------------------------------------
   function [15:0] mant;
      input [3:0] r;
      begin
         case (r)
            4'h0: mant = 16'h4000;
            4'h1: mant = 16'h43ce;
            4'h2: mant = 16'h47d6;
            4'h3: mant = 16'h4c1c;
            4'h4: mant = 16'h50a3;
            4'h5: mant = 16'h556e;
            4'h6: mant = 16'h5a82;
            4'h7: mant = 16'h5fe4;
            4'h8: mant = 16'h6598;
            4'h9: mant = 16'h6ba2;
            4'ha: mant = 16'h7209;
            default: mant = 16'h78d1;
         endcase
      end
   endfunction

   reg [8:0]  biased;
   reg [8:0]  expo;
   reg [8:0]  rem;
   reg signed [32:0] prod;
   reg signed [32:0] shifted;
   reg [5:0]  sh;

   always @* begin
      biased  = {code[7], code} + `DVM_GAIN_OFFSET;
      expo    = biased / `DVM_EXP_STEPS;
      rem     = biased % `DVM_EXP_STEPS;
      sh      = `DVM_SHIFT_BASE - expo[5:0];
      prod    = $signed({{17{sample[15]}}, sample}) *
                $signed({17'h00000, mant(rem[3:0])});
      shifted = prod >>> sh;
      // clip rather than wrap, +24 db easily overflows
      if (shifted > $signed({17'h00000, `DVM_SAMPLE_MAX}))
         result = `DVM_SAMPLE_MAX;
      else if (shifted < $signed({17'h1ffff, `DVM_SAMPLE_MIN}))
         result = `DVM_SAMPLE_MIN;
      else
         result = shifted[15:0];
   end
endmodule

//--- bench/dvm_checker.sv
// port checker for the volume and mute stage
// assumes a bind onto dvm_top, one clock pclk
`timescale 1ns/1ps
`include "dvm_defs.vh"
module dvm_checker (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        in_valid,
   input wire        out_valid,
   input wire [15:0] out_left,
   input wire [15:0] out_right
);
   // ----
   // shadow of both setup registers
   // ----
   logic [7:0] s1_reg;
   logic [7:0] s2_reg;
   wire        wr_ok = psel & penable & pready & pwrite & ~pslverr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= `DVM_RST_SETUP_ONE;
         s2_reg <= `DVM_RST_SETUP_TWO;
      end else if (wr_ok && paddr == 12'h0fc) begin
         s1_reg <= pwdata[7:0];
      end else if (wr_ok && paddr == 12'h100) begin
         s2_reg <= pwdata[7:0];
      end
   end
   // ----
   // relations
   // ----
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence apb_setup; psel && !penable; endsequence
   sequence apb_wait; psel && penable && !pready; endsequence
   a_ready_one_wait: assert property (apb_setup ##1 apb_wait |=> pready)
      else $error("pready not after one wait cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata nonzero outside answer");
   a_err_misaligned: assert property (pready && paddr[1:0] != 2'h0
      |-> pslverr) else $error("misaligned access not refused");
   a_out_latency: assert property (in_valid |=> out_valid)
      else $error("output not one cycle after sample");
   a_out_hold: assert property (!out_valid |-> $stable(out_left)
      && $stable(out_right)) else $error("output moved between samples");
   a_right_down: assert property (out_valid && !s1_reg[6] |-> out_right
      == (s2_reg[7] ? ~out_left : 16'h0))
      else $error("powered down right data wrong");
   a_left_down: assert property (out_valid && !s1_reg[7]
      |-> out_left == 16'h0) else $error("powered down left not zero");
endmodule
bind dvm_top dvm_checker chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .in_valid(in_valid), .out_valid(out_valid),
   .out_left(out_left), .out_right(out_right));

//--- bench/dvm_source.sv
// model of the serial audio source feeding stereo samples
// assumes the bench calls send right after a clock edge
`timescale 1ns/1ps
module dvm_source (
   input  wire         pclk,
   output logic        in_valid,
   output logic [15:0] in_left,
   output logic [15:0] in_right
);
   initial begin
      in_valid = 1'b0;
      in_left  = 16'h0;
      in_right = 16'h0;
   end
   // idle data inverted so a stale word never looks valid
   task automatic send(input logic [15:0] l, input logic [15:0] r,
                       input int gap);
      in_valid <= 1'b1;
      in_left  <= l;
      in_right <= r;
      @(posedge pclk);
      repeat (gap) begin
         in_valid <= 1'b0;
         in_left  <= ~l;
         in_right <= ~r;
         @(posedge pclk);
      end
   endtask
endmodule

//--- bench/dvm_top_tb.sv
// self-checking bench for the volume and mute stage
// assumes dvm_top, the source model and the bound checker
`timescale 1ns/1ps
module dvm_top_tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         in_valid;
   wire  [15:0] in_left;
   wire  [15:0] in_right;
   wire         out_valid;
   wire  [15:0] out_left;
   wire  [15:0] out_right;
   int          err_total;
   int          check_count;
   int          seed;
   logic [31:0] q;
   logic        e;
   logic [15:0] l;
   logic [15:0] r;
   dvm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .in_valid(in_valid), .in_left(in_left), .in_right(in_right),
      .out_valid(out_valid), .out_left(out_left), .out_right(out_right));
   dvm_source src (.pclk(pclk), .in_valid(in_valid), .in_left(in_left),
      .in_right(in_right));
   // ----
   // tasks
   // ----
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         err_total++;
         report_and_stop;
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] ex,
                      input logic ee);
      apb(1'b0, a, 8'h0);
      chk("prdata", ex, q);
      chk("pslverr", {31'h0, ee}, {31'h0, e});
   endtask
   // last sample idles two slots so outputs have landed
   task automatic burst(input int n, input logic fix, input logic [15:0] v);
      for (int i = 0; i < n; i++) begin
         l = fix ? v : 16'($random(seed));
         r = fix ? v : 16'($random(seed));
         src.send(l, r, (i == n - 1) ? 2 : $unsigned($random(seed)) % 3);
      end
   endtask
   // gain by 2 to the k, k below -20 means silent
   function automatic logic [15:0] gx(input logic [15:0] s, input int k);
      longint v;
      v = longint'($signed(s));
      if (k < -20) return 16'h0;
      v = (k >= 0) ? (v <<< k) : (v >>> (-k));
      if (v > 32767) v = 32767;
      if (v < -32768) v = -32768;
      return v[15:0];
   endfunction
   // kr of 99 means the inverted left output
   task automatic gain_case(input logic [7:0] cl, input logic [7:0] cr,
                            input int kl, input int kr);
      apb(1'b1, 12'h104, cl);
      apb(1'b1, 12'h108, cr);
      burst(3, 1'b0, 16'h0);
      chk("out_left", {16'h0, gx(l, kl)}, {16'h0, out_left});
      chk("out_right", {16'h0, (kr == 99) ? ~gx(l, kl) : gx(r, kr)},
          {16'h0, out_right});
   endtask
   task automatic amute(input logic b);
      apb(1'b0, 12'h140, 8'h0);
      chk("auto mute", {31'h0, b}, {31'h0, q[16]});
   endtask
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ----
   // main sequence
   // ----
   initial begin
      seed = 17;
      err_total = 0;
      check_count = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc(12'h0fc, 32'h14, 1'b0);
      rdc(12'h100, 32'h0c, 1'b0);
      rdc(12'h104, 32'h00, 1'b0);
      rdc(12'h108, 32'h00, 1'b0);
      rdc(12'h140, 32'h8181, 1'b0);
      rdc(12'h144, 32'h0, 1'b1);
      rdc(12'h0fd, 32'h0, 1'b1);
      apb(1'b1, 12'h140, 8'h55);
      chk("status write", 32'h1, {31'h0, e});
      $display("test registers done");
      apb(1'b1, 12'h0fc, 8'hc2);
      apb(1'b1, 12'h100, 8'h00);
      gain_case(8'h00, 8'h00, 0, 0);
      apb(1'b1, 12'h0fc, 8'hc0);
      apb(1'b1, 12'h104, 8'h0c);
      burst(5, 1'b0, 16'h0);
      rdc(12'h140, 32'h0005, 1'b0);
      apb(1'b1, 12'h0fc, 8'hc1);
      apb(1'b1, 12'h104, 8'h00);
      burst(8, 1'b0, 16'h0);
      rdc(12'h140, 32'h0001, 1'b0);
      apb(1'b1, 12'h0fc, 8'hc2);
      $display("test ramp done");
      gain_case(8'h30, 8'hf4, 4, -1);
      gain_case(8'h0c, 8'h30, 1, 4);
      apb(1'b1, 12'h100, 8'h01);
      gain_case(8'h00, 8'h0c, 1, 1);
      apb(1'b1, 12'h100, 8'h02);
      gain_case(8'hf4, 8'h00, -1, -1);
      apb(1'b1, 12'h100, 8'h00);
      gain_case(8'h00, 8'h0c, 0, 1);
      $display("test gain and link done");
      apb(1'b1, 12'h100, 8'h08);
      gain_case(8'h00, 8'h00, -99, 0);
      apb(1'b1, 12'h100, 8'h04);
      gain_case(8'h00, 8'h00, 0, -99);
      apb(1'b1, 12'h0fc, 8'h82);
      apb(1'b1, 12'h100, 8'h80);
      gain_case(8'h00, 8'h00, 0, 99);
      apb(1'b1, 12'h100, 8'h00);
      gain_case(8'h00, 8'h00, 0, -99);
      apb(1'b1, 12'h0fc, 8'h02);
      gain_case(8'h00, 8'h00, -99, -99);
      apb(1'b1, 12'h0fc, 8'hc2);
      $display("test mute and power done");
      for (int c = 1; c < 8; c++) begin
         apb(1'b1, 12'h100, {1'b0, c[2:0], 4'h0});
         // the first word resets the count, so this leaves it one short of the threshold
         burst(100 << (c - 1), 1'b1, 16'h1234);
         amute(1'b0);
         burst(1, 1'b1, 16'h1234);
         amute(1'b1);
         burst(2, 1'b0, 16'h0);
         amute(1'b0);
      end
      $display("test auto mute done");
      report_and_stop;
   end
endmodule
